// [core/dqpme_top.sv]
`timescale 1ns/10ps
`default_nettype none
module dqpme_top #(
  parameter int TR_W = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event sources, one bit per channel, one-cycle pulses
  input wire logic [63:0] manual_trigger_set,
  input wire logic [63:0] chain_trigger_pending,
  input wire logic [63:0] hardware_trigger_pending,
  input wire logic [63:0] manual_serviced,
  input wire logic [63:0] chain_serviced,
  input wire logic [63:0] hardware_serviced,
  input wire logic [63:0] null_entry_hit,
  // Other error registers of the controller, non-zero while any is set
  input wire logic other_error_flags,
  // Queue zero to transfer engine zero
  input wire logic queue_zero_valid,
  input wire logic [TR_W-1:0] queue_zero_request,
  output logic queue_zero_ready,
  output logic transfer_engine_zero_valid,
  output logic [TR_W-1:0] transfer_engine_zero_request,
  output logic [2:0] transfer_engine_zero_priority,
  input wire logic transfer_engine_zero_ready,
  // Queue one to transfer engine one
  input wire logic queue_one_valid,
  input wire logic [TR_W-1:0] queue_one_request,
  output logic queue_one_ready,
  output logic transfer_engine_one_valid,
  output logic [TR_W-1:0] transfer_engine_one_request,
  output logic [2:0] transfer_engine_one_priority,
  input wire logic transfer_engine_one_ready,
  // Interrupts
  output logic error_interrupt,
  output logic irq
);
  import dqpme_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [2:0] queue_zero_priority_level_q;
  logic [2:0] queue_one_priority_level_q;
  logic [63:0] missed_q;
  logic [63:0] missed_d;
  logic [1:0] int_status_q;
  logic [1:0] int_status_d;
  logic [1:0] int_mask_q;
  logic error_interrupt_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  dqpme_bus_t bus_q;
  dqpme_bus_t bus_d;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Access is taken in the cycle that pready is already high
  wire access = psel & penable;
  wire commit = access & (bus_q == DQPME_BUS_DONE);
  wire wr_commit = commit & pwrite;
  wire hit_qpri = (paddr == DQPME_OFF_QUEUE_PRIORITY);
  wire hit_mlo = (paddr == DQPME_OFF_MISSED_LOW);
  wire hit_mhi = (paddr == DQPME_OFF_MISSED_HIGH);
  wire hit_clo = (paddr == DQPME_OFF_CLEAR_LOW);
  wire hit_chi = (paddr == DQPME_OFF_CLEAR_HIGH);
  wire hit_ist = (paddr == DQPME_OFF_INT_STATUS);
  wire hit_imk = (paddr == DQPME_OFF_INT_MASK);
  wire mapped = hit_qpri | hit_mlo | hit_mhi | hit_clo | hit_chi | hit_ist | hit_imk;
  wire wr_qpri = wr_commit & hit_qpri;
  wire wr_ist = wr_commit & hit_ist;
  wire wr_imk = wr_commit & hit_imk;
  wire [31:0] wmasked_qpri = pwdata & DQPME_QPRI_WMASK;
  // Clear vector: only ones written to a clear register act
  wire [63:0] clear_vec = {(wr_commit & hit_chi) ? pwdata : DQPME_WORD_ZERO,
                           (wr_commit & hit_clo) ? pwdata : DQPME_WORD_ZERO};

  // Read mux: reserved bits are zero, clear registers read zero
  wire [31:0] qpri_word = {25'h0, queue_one_priority_level_q, 1'b0,
                           queue_zero_priority_level_q};
  wire [31:0] rd_word =
      hit_qpri ? qpri_word :
      hit_mlo ? missed_q[DQPME_HALF-1:0] :
      hit_mhi ? missed_q[DQPME_CHANNELS-1:DQPME_HALF] :
      hit_ist ? {30'h0, int_status_q} :
      hit_imk ? {30'h0, int_mask_q} :
      DQPME_WORD_ZERO;

  // Bus answer sequencing: one wait state, then ready for one cycle
  assign bus_d = (access && bus_q == DQPME_BUS_IDLE) ? DQPME_BUS_DONE : DQPME_BUS_IDLE;

  // ----------------------------------------------------------------
  // Trigger tracking, one instance per trigger type
  // ----------------------------------------------------------------
  logic [63:0] man_miss;
  logic [63:0] chn_miss;
  logic [63:0] hw_miss;

  dqpme_trig_track #(.WIDTH(DQPME_CHANNELS)) u_track_manual (
    .clk(clk),
    .sys_rst(sys_rst),
    .trig(manual_trigger_set),
    .serviced(manual_serviced),
    .pending(),
    .missed(man_miss)
  );

  dqpme_trig_track #(.WIDTH(DQPME_CHANNELS)) u_track_chain (
    .clk(clk),
    .sys_rst(sys_rst),
    .trig(chain_trigger_pending),
    .serviced(chain_serviced),
    .pending(),
    .missed(chn_miss)
  );

  dqpme_trig_track #(.WIDTH(DQPME_CHANNELS)) u_track_hw (
    .clk(clk),
    .sys_rst(sys_rst),
    .trig(hardware_trigger_pending),
    .serviced(hardware_serviced),
    .pending(),
    .missed(hw_miss)
  );

  // ----------------------------------------------------------------
  // Missed-event flags
  // ----------------------------------------------------------------
  // Each type misses on its own; a null entry also counts as a miss
  wire [63:0] miss_set = man_miss | chn_miss | hw_miss | null_entry_hit;
  // Set wins over a clear written in the same cycle
  assign missed_d = (missed_q & ~clear_vec) | miss_set;
  wire new_flag = |(miss_set & ~missed_q);
  wire all_clear = ~(|missed_q) & ~other_error_flags;
  // Interrupt only when the error state starts from fully clear
  wire err_event = new_flag & all_clear;

  // Sticky interrupt status, cleared by writing one; set beats clear
  assign int_status_d = (int_status_q & ~(wr_ist ? pwdata[1:0] : 2'h0)) |
                        {|miss_set, err_event};

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Queue priority fields, zero is the highest rank
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      queue_zero_priority_level_q <= DQPME_PRI_RESET;
      queue_one_priority_level_q <= DQPME_PRI_RESET;
    end else if (wr_qpri) begin
      queue_zero_priority_level_q <= wmasked_qpri[DQPME_Q0_LSB +: DQPME_PRI_W];
      queue_one_priority_level_q <= wmasked_qpri[DQPME_Q1_LSB +: DQPME_PRI_W];
    end
  end

  // Missed flags and error interrupt pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      missed_q <= '0;
      error_interrupt_q <= 1'b0;
    end else begin
      missed_q <= missed_d;
      error_interrupt_q <= err_event;
    end
  end

  // Interrupt status, mask and level output
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_status_q <= DQPME_INT_RESET;
      int_mask_q <= DQPME_INT_RESET;
      irq_q <= 1'b0;
    end else begin
      int_status_q <= int_status_d;
      if (wr_imk) begin
        int_mask_q <= pwdata[1:0];
      end
      irq_q <= |(int_status_d & int_mask_q);
    end
  end

  // Bus answer registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_q <= DQPME_BUS_IDLE;
      prdata_q <= DQPME_WORD_ZERO;
      pslverr_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      prdata_q <= (bus_d == DQPME_BUS_DONE && !pwrite) ? rd_word : DQPME_WORD_ZERO;
      pslverr_q <= (bus_d == DQPME_BUS_DONE) & ~mapped;
    end
  end

  assign pready = (bus_q == DQPME_BUS_DONE);
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign error_interrupt = error_interrupt_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Queue to engine paths
  // ----------------------------------------------------------------
  dqpme_queue_port #(.DATA_W(TR_W)) u_port_zero (
    .clk(clk),
    .sys_rst(sys_rst),
    .priority_level(queue_zero_priority_level_q),
    .in_valid(queue_zero_valid),
    .in_data(queue_zero_request),
    .in_ready(queue_zero_ready),
    .out_valid(transfer_engine_zero_valid),
    .out_data(transfer_engine_zero_request),
    .out_priority(transfer_engine_zero_priority),
    .out_ready(transfer_engine_zero_ready)
  );

  dqpme_queue_port #(.DATA_W(TR_W)) u_port_one (
    .clk(clk),
    .sys_rst(sys_rst),
    .priority_level(queue_one_priority_level_q),
    .in_valid(queue_one_valid),
    .in_data(queue_one_request),
    .in_ready(queue_one_ready),
    .out_valid(transfer_engine_one_valid),
    .out_data(transfer_engine_one_request),
    .out_priority(transfer_engine_one_priority),
    .out_ready(transfer_engine_one_ready)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_pri_write;
    wr_qpri;
  endsequence

  a_q0_pri_write: assert property (s_pri_write |=>
      queue_zero_priority_level_q == $past(pwdata[2:0]))
    else $error("queue zero priority not stored");
  a_q1_pri_write: assert property (s_pri_write |=>
      queue_one_priority_level_q == $past(pwdata[6:4]))
    else $error("queue one priority not stored");
  a_engine_pri_follow: assert property ($changed(queue_zero_priority_level_q) |=>
      transfer_engine_zero_priority == $past(queue_zero_priority_level_q))
    else $error("engine zero priority not applied");
  a_miss_sets_flag: assert property (|miss_set |=>
      (missed_q & $past(miss_set)) == $past(miss_set))
    else $error("missed event not flagged");
  a_null_sets_flag: assert property (|null_entry_hit |=>
      (missed_q & $past(null_entry_hit)) == $past(null_entry_hit))
    else $error("null entry not flagged");
  a_err_only_clear: assert property (error_interrupt |->
      $past(missed_q) == 64'h0 && $past(|miss_set) && !$past(other_error_flags))
    else $error("error interrupt without clean start");
  a_err_from_clear: assert property (err_event |=> error_interrupt)
    else $error("error interrupt missing");
  a_flag_no_selfclr: assert property ((missed_q != 64'h0) && !(wr_commit && (hit_clo || hit_chi))
      |=> (missed_q & $past(missed_q)) == $past(missed_q))
    else $error("flag cleared without clear write");
  a_set_beats_clr: assert property ((|(miss_set & clear_vec)) |=>
      (missed_q & $past(miss_set & clear_vec)) == $past(miss_set & clear_vec))
    else $error("clear won over set");
  a_rsvd_read_zero: assert property (pready && !pwrite && hit_qpri |->
      (prdata & ~DQPME_QPRI_WMASK) == 32'h0)
    else $error("reserved bits read non-zero");

  // ----------------------------------------------------------------
  // Queue path checks
  // ----------------------------------------------------------------
  // A request taken from a queue shows up at its own engine
  sequence s_q0_take;
    queue_zero_valid && queue_zero_ready;
  endsequence

  sequence s_q1_take;
    queue_one_valid && queue_one_ready;
  endsequence

  a_q0_route: assert property (s_q0_take |=>
      transfer_engine_zero_valid && transfer_engine_zero_request == $past(queue_zero_request))
    else $error("queue zero request not routed");
  a_q1_route: assert property (s_q1_take |=>
      transfer_engine_one_valid && transfer_engine_one_request == $past(queue_one_request))
    else $error("queue one request not routed");
  // An offered request stays put until its engine accepts it
  a_q0_hold: assert property (transfer_engine_zero_valid && !transfer_engine_zero_ready |=>
      transfer_engine_zero_valid && $stable(transfer_engine_zero_request))
    else $error("engine zero request dropped");
  a_q1_hold: assert property (transfer_engine_one_valid && !transfer_engine_one_ready |=>
      transfer_engine_one_valid && $stable(transfer_engine_one_request))
    else $error("engine one request dropped");
  a_q1_pri_follow: assert property ($changed(queue_one_priority_level_q) |=>
      transfer_engine_one_priority == $past(queue_one_priority_level_q))
    else $error("engine one priority not applied");

  // ----------------------------------------------------------------
  // Register read and clear checks
  // ----------------------------------------------------------------
  // A completed read carries the flags as they stood one cycle earlier
  sequence s_rd_done;
    pready && !pwrite;
  endsequence

  a_pready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_mlo_read: assert property (s_rd_done ##0 hit_mlo |->
      prdata == $past(missed_q[DQPME_HALF-1:0]))
    else $error("low missed flags read wrong");
  a_mhi_read: assert property (s_rd_done ##0 hit_mhi |->
      prdata == $past(missed_q[DQPME_CHANNELS-1:DQPME_HALF]))
    else $error("high missed flags read wrong");
  // A one clears its flag unless a new miss lands in that cycle
  a_clear_acts: assert property (wr_commit && hit_clo |=>
      (missed_q[DQPME_HALF-1:0] & $past(pwdata) & ~$past(miss_set[DQPME_HALF-1:0])) == 32'h0)
    else $error("clear write left flag set");
  // A zero in a clear write leaves its flag alone
  a_zero_keeps: assert property (wr_commit && hit_clo |=>
      (missed_q[DQPME_HALF-1:0] & $past(missed_q[DQPME_HALF-1:0]) & ~$past(pwdata)) ==
      ($past(missed_q[DQPME_HALF-1:0]) & ~$past(pwdata)))
    else $error("zero in clear write removed flag");

  // ----------------------------------------------------------------
  // Interrupt checks
  // ----------------------------------------------------------------
  a_no_err_dirty: assert property (new_flag && !all_clear |=> !error_interrupt)
    else $error("error interrupt while errors pending");
  a_err_one_pulse: assert property (error_interrupt |=> !error_interrupt)
    else $error("error interrupt longer than a pulse");
  // An unmasked status bit keeps the level output up
  a_irq_on_mask: assert property (|(int_status_q & int_mask_q) && !wr_ist |=> irq)
    else $error("interrupt output low with unmasked status");
endmodule // dqpme_top
`default_nettype wire

// [core/dqpme_pkg.sv]
//
// Contract
// - Queue zero priority in bits 2:0, reset zero
// - Queue one priority in bits 6:4, reset zero
// - Code zero highest priority, seven lowest
// - Queue priority drives its engine's arbitration
// - First error flag set from all clear raises error interrupt
// - Second event while pending sets missed flag
// - Manual, chain, hardware triggers tracked separately
// - Null entry or null request sets missed flag; only null_entry_hit is an input, no null request is detected
// - New flag interrupts only if all were clear
// - Low missed register: channels 0-31, read-only
// - Flag clears only by writing one to clear
// - High missed register: bit k is channel 32+k
// - Writing zero to clear register does nothing
// - Queue n feeds transfer engine n
`default_nettype none
package dqpme_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] DQPME_OFF_QUEUE_PRIORITY = 8'h00;
  localparam logic [7:0] DQPME_OFF_MISSED_LOW = 8'h04;
  localparam logic [7:0] DQPME_OFF_MISSED_HIGH = 8'h08;
  localparam logic [7:0] DQPME_OFF_CLEAR_LOW = 8'h0C;
  localparam logic [7:0] DQPME_OFF_CLEAR_HIGH = 8'h10;
  localparam logic [7:0] DQPME_OFF_INT_STATUS = 8'h14;
  localparam logic [7:0] DQPME_OFF_INT_MASK = 8'h18;
  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int DQPME_PRI_W = 3;
  localparam int DQPME_Q0_LSB = 0;
  localparam int DQPME_Q1_LSB = 4;
  localparam logic [2:0] DQPME_PRI_RESET = 3'h0;
  localparam logic [31:0] DQPME_QPRI_WMASK = 32'h0000_0077;
  localparam int DQPME_CHANNELS = 64;
  localparam int DQPME_HALF = 32;
  localparam int DQPME_INT_W = 2;
  localparam int DQPME_INT_ERROR = 0;
  localparam int DQPME_INT_MISSED = 1;
  localparam logic [1:0] DQPME_INT_RESET = 2'h0;
  localparam logic [31:0] DQPME_WORD_ZERO = 32'h0000_0000;
  // Bus answer state
  typedef enum logic [0:0] {
    DQPME_BUS_IDLE = 1'b0,
    DQPME_BUS_DONE = 1'b1
  } dqpme_bus_t;
endpackage
`default_nettype wire

// [core/dqpme_trig_track.sv]
`timescale 1ns/10ps
`default_nettype none
module dqpme_trig_track #(
  parameter int WIDTH = 64
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] trig,
  input wire logic [WIDTH-1:0] serviced,
  output logic [WIDTH-1:0] pending,
  output logic [WIDTH-1:0] missed
);
  logic [WIDTH-1:0] pending_q;
  logic [WIDTH-1:0] pending_d;

  // A new trigger while the previous one is still waiting is a miss
  assign missed = trig & pending_q & ~serviced;
  assign pending_d = (pending_q & ~serviced) | trig;
  assign pending = pending_q;

  // Pending state for one trigger type
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending_q <= '0;
    end else begin
      pending_q <= pending_d;
    end
  end
endmodule // dqpme_trig_track
`default_nettype wire

// [core/dqpme_queue_port.sv]
`timescale 1ns/10ps
`default_nettype none
module dqpme_queue_port #(
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] priority_level,
  input wire logic in_valid,
  input wire logic [DATA_W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [DATA_W-1:0] out_data,
  output logic [2:0] out_priority,
  input wire logic out_ready
);
  logic valid_q;
  logic empty_q;
  logic [DATA_W-1:0] data_q;
  logic [2:0] pri_q;
  wire take = in_valid & empty_q;
  wire drain = valid_q & out_ready;

  assign in_ready = empty_q;
  assign out_valid = valid_q;
  assign out_data = data_q;
  assign out_priority = pri_q;

  // One-entry slot from queue to its own engine
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
      empty_q <= 1'b1;
      data_q <= '0;
      pri_q <= 3'h0;
    end else begin
      pri_q <= priority_level;
      if (take) begin
        valid_q <= 1'b1;
        empty_q <= 1'b0;
        data_q <= in_data;
      end else if (drain) begin
        valid_q <= 1'b0;
        empty_q <= 1'b1;
      end
    end
  end
endmodule // dqpme_queue_port
`default_nettype wire

// [verification/dqpme_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Both transfer engines, accepting after a settable delay
module dqpme_engine_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] wait_cycles,
  input wire logic zero_valid,
  input wire logic one_valid,
  output logic zero_ready,
  output logic one_ready
);
  logic [3:0] zero_q;
  logic [3:0] one_q;
  // Accept once a request has been held long enough
  assign zero_ready = zero_valid && (zero_q >= wait_cycles);
  assign one_ready = one_valid && (one_q >= wait_cycles);
  // Count cycles the current request has waited
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_q <= 4'h0;
      one_q <= 4'h0;
    end else begin
      zero_q <= (zero_valid && !zero_ready) ? zero_q + 4'h1 : 4'h0;
      one_q <= (one_valid && !one_ready) ? one_q + 4'h1 : 4'h0;
    end
  end
endmodule // dqpme_engine_model
`default_nettype wire

// [verification/dqpme_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); end end
module dqpme_tb_top;
  import dqpme_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, error_interrupt, irq;
  logic [63:0] manual_trigger_set = 64'h0, chain_trigger_pending = 64'h0;
  logic [63:0] hardware_trigger_pending = 64'h0, manual_serviced = 64'h0;
  logic [63:0] null_entry_hit = 64'h0, chain_serviced = 64'h0, hardware_serviced = 64'h0;
  logic other_error_flags = 1'b0;
  logic queue_zero_valid = 1'b0, queue_one_valid = 1'b0, queue_zero_ready, queue_one_ready;
  logic [31:0] queue_zero_request = 32'h0, queue_one_request = 32'h0;
  logic transfer_engine_zero_valid, transfer_engine_one_valid;
  logic transfer_engine_zero_ready, transfer_engine_one_ready;
  logic [31:0] transfer_engine_zero_request, transfer_engine_one_request;
  logic [2:0] transfer_engine_zero_priority, transfer_engine_one_priority;
  logic [3:0] wait_cycles = 4'h0;
  int n_errors = 0, checks_done = 0, pulses = 0;

  dqpme_top #(.TR_W(32)) dqpme_top_i (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .manual_trigger_set, .chain_trigger_pending, .hardware_trigger_pending,
    .manual_serviced, .chain_serviced, .hardware_serviced, .null_entry_hit,
    .other_error_flags, .queue_zero_valid, .queue_zero_request, .queue_zero_ready,
    .transfer_engine_zero_valid, .transfer_engine_zero_request,
    .transfer_engine_zero_priority, .transfer_engine_zero_ready,
    .queue_one_valid, .queue_one_request, .queue_one_ready, .transfer_engine_one_valid,
    .transfer_engine_one_request, .transfer_engine_one_priority,
    .transfer_engine_one_ready, .error_interrupt, .irq);
  dqpme_engine_model dqpme_engine_model_i (.clk, .sys_rst, .wait_cycles,
    .zero_valid(transfer_engine_zero_valid), .one_valid(transfer_engine_one_valid),
    .zero_ready(transfer_engine_zero_ready), .one_ready(transfer_engine_one_ready));

  // Clock and error pulse counter
  always #5 clk = ~clk;
  always @(posedge clk) if (error_interrupt === 1'b1) pulses++;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic bail;
    n_errors++;
    $display("mismatch t=%0t timeout", $time);
    tally_and_finish();
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) bail();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // One-cycle pulse: 0-2 manual, chain, hw trigger; 3, 5, 6 their service; 4 null
  task automatic ev(input int t, input int ch);
    logic [63:0] v;
    v = 64'h1 << ch;
    @(posedge clk);
    case (t)
      0: manual_trigger_set <= v;
      1: chain_trigger_pending <= v;
      2: hardware_trigger_pending <= v;
      3: manual_serviced <= v;
      5: chain_serviced <= v;
      6: hardware_serviced <= v;
      default: null_entry_hit <= v;
    endcase
    @(posedge clk);
    manual_trigger_set <= 64'h0;
    chain_trigger_pending <= 64'h0;
    hardware_trigger_pending <= 64'h0;
    manual_serviced <= 64'h0;
    chain_serviced <= 64'h0;
    hardware_serviced <= 64'h0;
    null_entry_hit <= 64'h0;
  endtask

  task automatic t_queue(input logic [3:0] w, input logic [31:0] d, input logic [2:0] p0, p1);
    int k;
    bit g0, g1;
    g0 = 1'b0;
    g1 = 1'b0;
    @(posedge clk);
    wait_cycles <= w;
    queue_zero_valid <= 1'b1;
    queue_one_valid <= 1'b1;
    queue_zero_request <= d;
    queue_one_request <= ~d;
    @(posedge clk);
    `CHK({queue_zero_ready, queue_one_ready}, 2'h3)
    queue_zero_valid <= 1'b0;
    queue_one_valid <= 1'b0;
    for (k = 0; k < 20 && !(g0 && g1); k++) begin
      @(posedge clk);
      if (transfer_engine_zero_valid === 1'b1 && transfer_engine_zero_ready === 1'b1) begin
        g0 = 1'b1;
        `CHK({transfer_engine_zero_priority, transfer_engine_zero_request}, {p0, d})
      end
      if (transfer_engine_one_valid === 1'b1 && transfer_engine_one_ready === 1'b1) begin
        g1 = 1'b1;
        `CHK({transfer_engine_one_priority, transfer_engine_one_request}, {p1, ~d})
      end
    end
    if (!(g0 && g1)) bail();
  endtask

  task automatic t_regs;
    rdchk(DQPME_OFF_QUEUE_PRIORITY, 32'h0);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h0);
    rdchk(DQPME_OFF_MISSED_HIGH, 32'h0);
    rdchk(8'h40, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, DQPME_OFF_QUEUE_PRIORITY, 32'hFFFF_FFFF);
    rdchk(DQPME_OFF_QUEUE_PRIORITY, 32'h0000_0077);
    apb(1'b1, DQPME_OFF_QUEUE_PRIORITY, 32'h0000_0053);
    rdchk(DQPME_OFF_QUEUE_PRIORITY, 32'h0000_0053);
    t_queue(4'h0, 32'hA5A5_0001, 3'h3, 3'h5);
    apb(1'b1, DQPME_OFF_QUEUE_PRIORITY, 32'h0000_0070);
    t_queue(4'h3, 32'h5A5A_0002, 3'h0, 3'h7);
    $display("test regs_and_queues done");
  endtask

  task automatic t_missed;
    ev(0, 3);
    ev(0, 3);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h8);
    `CHK(pulses, 1)
    ev(1, 3);
    ev(2, 3);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h8);
    ev(2, 40);
    ev(2, 40);
    rdchk(DQPME_OFF_MISSED_HIGH, 32'h100);
    `CHK(pulses, 1)
    apb(1'b1, DQPME_OFF_MISSED_LOW, 32'hFFFF_FFFF);
    apb(1'b1, DQPME_OFF_CLEAR_LOW, 32'h0);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h8);
    apb(1'b1, DQPME_OFF_CLEAR_LOW, 32'h8);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h0);
    apb(1'b1, DQPME_OFF_INT_MASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, DQPME_OFF_INT_MASK, 32'h3);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, DQPME_OFF_CLEAR_HIGH, 32'hFFFF_FFFF);
    rdchk(DQPME_OFF_MISSED_HIGH, 32'h0);
    apb(1'b1, DQPME_OFF_INT_STATUS, 32'h3);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    ev(4, 5);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h20);
    `CHK({pulses, irq}, {32'd2, 1'b1})
    ev(3, 3);
    ev(0, 3);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h20);
    $display("test missed_events done");
  endtask

  // Set against clear in one cycle, other errors, per-type servicing
  task automatic t_corner;
    @(posedge clk);
    null_entry_hit <= 64'h20;
    apb(1'b1, DQPME_OFF_CLEAR_LOW, 32'h20);
    null_entry_hit <= 64'h0;
    rdchk(DQPME_OFF_MISSED_LOW, 32'h20);
    apb(1'b1, DQPME_OFF_CLEAR_LOW, 32'h20);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h0);
    @(posedge clk);
    other_error_flags <= 1'b1;
    ev(2, 9);
    ev(2, 9);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h200);
    `CHK(pulses, 2)
    apb(1'b1, DQPME_OFF_CLEAR_LOW, 32'h200);
    other_error_flags <= 1'b0;
    ev(6, 9);
    ev(2, 9);
    ev(1, 9);
    ev(5, 9);
    ev(1, 9);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h0);
    ev(1, 9);
    rdchk(DQPME_OFF_MISSED_LOW, 32'h200);
    `CHK(pulses, 3)
    $display("test corner_cases done");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_missed();
    t_corner();
    tally_and_finish();
  end
endmodule // dqpme_tb_top
`default_nettype wire
